/* File: rtl/dsr_deser_ctrl.sv */
// deserializer: frame alignment, lock tracking, recovered clock and pin gating
// Behaviour
// [R1] strobe select high: word captured on recovered clock rising edge, low: falling
// [R2] power down stops recovery and floats data, lock and recovered clock
// [R3] lock indicator low once locked to embedded clock, high otherwise
// [R4] output enable low floats data and recovered clock; lock stays driven
// [R5] while unlocked, data and recovered clock float
// [R6] recovered clock toggles only while locked, one period per word
// [R7] each word delivered as ten parallel bits
// [R8] link carries ten bits per word clock: 400 Mbps at 40 MHz
// [R9] lock acquired from sync patterns or from arbitrary framed data
// [R10] far end guarantees a transition every word via clock bits
// [R11] system supplies a running local reference clock
// [R12] lock lost only after four consecutive bad words
// [R13] lock indicator may be fed back to far end sync request
// [R14] frame is high clock bit, ten data bits, low clock bit
`timescale 1ns/1ps
module dsr_deser_ctrl #(
  parameter logic [2:0] ACQ_GOOD = dsr_pkg::ACQ_GOOD_DEFAULT,
  parameter int BUF_WORDS = dsr_pkg::BUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_local_ref_clk,
  input wire logic i_serial_in_pos,
  input wire logic i_serial_in_neg,
  input wire logic i_power_down_n,
  input wire logic i_output_enable_n,
  input wire logic i_strobe_edge_select,
  input wire logic i_rx_ready,
  output dsr_pkg::dsr_pins_t o_pins,
  output logic o_ref_seen,
  output logic o_buf_ready,
  output logic o_word_dropped
);
  import dsr_pkg::*;

  typedef struct packed {
    dsr_state_t state;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_CNT_W-1:0] bit_cnt;
    logic [2:0] good_cnt;
    logic [2:0] bad_cnt;
    logic push;
    logic [DATA_BITS-1:0] push_data;
    logic [FRAME_CNT_W-1:0] pres_cnt;
    logic [DATA_BITS-1:0] word;
    logic ref_q;
    logic ref_seen;
    logic buf_ready;
    logic dropped;
    dsr_pins_t pins;
  } dsrc_st_t;

  dsrc_st_t st_ff;
  dsrc_st_t nxt_st;
  logic ser_bit;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_BITS-1:0] buf_out_data;
  logic pop;
  logic flush;

  function automatic logic frame_ok(input logic [FRAME_BITS-1:0] f);
    frame_ok = f[FRAME_BITS-1] & ~f[0];
  endfunction : frame_ok

  function automatic logic [FRAME_CNT_W-1:0] cnt_inc(input logic [FRAME_CNT_W-1:0] c);
    cnt_inc = (c == FRAME_LAST) ? '0 : c + 1'b1;
  endfunction : cnt_inc

  dsr_bit_sampler u_sampler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_pos(i_serial_in_pos),
    .i_neg(i_serial_in_neg),
    .o_bit(ser_bit)
  );

  dsr_word_buf #(
    .WIDTH(DATA_BITS),
    .DEPTH(BUF_WORDS)
  ) u_buf (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_flush(flush),
    .i_in_valid(st_ff.push),
    .i_in_data(st_ff.push_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(pop)
  );

  // a new word is presented at the start of a recovered clock period when i_rx_ready is high and a word is buffered
  assign pop = (st_ff.state == ST_LOCKED) && (st_ff.pres_cnt == FRAME_LAST) && i_rx_ready;
  assign flush = (st_ff.state != ST_LOCKED);

  always_comb begin
    logic [FRAME_BITS-1:0] sh;
    logic locked;
    logic rclk_hi;
    sh = '0;
    locked = 1'b0;
    rclk_hi = 1'b0;
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.push = 1'b0;
      // besides words flushed or not pushed when lock is lost, a word is lost only when the buffer refuses the push now on its input
      nxt_st.dropped = st_ff.push & ~buf_in_ready; // R7
      nxt_st.ref_q = i_local_ref_clk;
      nxt_st.ref_seen = st_ff.ref_q ^ i_local_ref_clk; // R11
      sh = {st_ff.shift[FRAME_BITS-2:0], ser_bit};
      nxt_st.shift = sh;
      nxt_st.bit_cnt = cnt_inc(st_ff.bit_cnt);
      unique case (st_ff.state)
        ST_OFF: begin
          nxt_st.state = ST_HUNT;
          nxt_st.good_cnt = '0;
          nxt_st.bad_cnt = '0;
        end
        ST_HUNT: begin
          // random lock: any bit position showing a framed word is tried
          if (frame_ok(sh)) begin // R9 R14
            nxt_st.state = ST_CHECK;
            nxt_st.bit_cnt = '0;
            nxt_st.good_cnt = 3'h1;
          end
        end
        ST_CHECK: begin
          if (st_ff.bit_cnt == FRAME_LAST) begin
            if (!frame_ok(sh)) begin
              nxt_st.state = ST_HUNT;
            end else if (st_ff.good_cnt + 3'h1 >= ACQ_GOOD) begin
              nxt_st.state = ST_LOCKED; // R9
              nxt_st.bad_cnt = '0;
              nxt_st.pres_cnt = '0;
            end else begin
              nxt_st.good_cnt = st_ff.good_cnt + 3'h1;
            end
          end
        end
        ST_LOCKED: begin
          if (st_ff.bit_cnt == FRAME_LAST) begin
            // words seen before loss is declared are still pushed to the buffer
            nxt_st.push = 1'b1;
            nxt_st.push_data = sh[FRAME_BITS-2:1]; // R7 R14
            if (frame_ok(sh)) begin
              nxt_st.bad_cnt = '0;
            end else if (st_ff.bad_cnt + 3'h1 == LOSS_LIMIT) begin
              nxt_st.state = ST_HUNT; // R12
              nxt_st.push = 1'b0;
            end else begin
              nxt_st.bad_cnt = st_ff.bad_cnt + 3'h1; // R12
            end
          end
        end
      endcase
      nxt_st.pres_cnt = (st_ff.state == ST_LOCKED) ? cnt_inc(st_ff.pres_cnt) : '0;
      if (pop) begin
        nxt_st.word = buf_out_valid ? buf_out_data : st_ff.word;
      end
      nxt_st.buf_ready = buf_in_ready;
      // power down holds the recovery logic idle
      if (!i_power_down_n) begin // R2
        nxt_st.state = ST_OFF;
        nxt_st.push = 1'b0;
        nxt_st.pres_cnt = '0;
      end
      locked = (nxt_st.state == ST_LOCKED);
      rclk_hi = (nxt_st.pres_cnt >= RCLK_HALF);
      nxt_st.pins.data = nxt_st.word; // R7
      nxt_st.pins.lock_n = ~locked; // R3
      nxt_st.pins.lock_oe = i_power_down_n; // R2 R4
      // output enable low floats the data and clock pins
      nxt_st.pins.data_oe = i_power_down_n & i_output_enable_n & locked; // R2 R4 R5
      nxt_st.pins.rclk_oe = i_power_down_n & i_output_enable_n & locked; // R2 R4 R5
      // word changes at count 0; the chosen strobe edge lands mid word
      nxt_st.pins.rclk = locked & (rclk_hi ^ ~i_strobe_edge_select); // R1 R6 R8
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
      st_ff.state <= ST_OFF;
      st_ff.pins.lock_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pins = st_ff.pins;
  assign o_ref_seen = st_ff.ref_seen;
  assign o_buf_ready = st_ff.buf_ready;
  assign o_word_dropped = st_ff.dropped;
endmodule : dsr_deser_ctrl

/* File: rtl/dsr_pkg.sv */
// constants and types shared by the deserializer output controller
package dsr_pkg;
  localparam int DATA_BITS = 10;
  localparam int FRAME_BITS = 12;
  localparam int FRAME_CNT_W = 4;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 4'hB;
  localparam logic [FRAME_CNT_W-1:0] RCLK_HALF = 4'h6;
  localparam int LOSS_WORDS = 4;
  localparam logic [2:0] LOSS_LIMIT = 3'h4;
  localparam logic [2:0] ACQ_GOOD_DEFAULT = 3'h2;
  localparam int WORD_CLK_MHZ = 40;
  localparam int LINK_MBPS = 400;
  localparam int BITS_PER_WORD = LINK_MBPS / WORD_CLK_MHZ;
  localparam int BUF_DEPTH = 2;
  localparam logic [DATA_BITS-1:0] DATA_RST = 10'h000;

  typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_CHECK, ST_LOCKED} dsr_state_t;

  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic data_oe;
    logic rclk;
    logic rclk_oe;
    logic lock_n;
    logic lock_oe;
  } dsr_pins_t;
endpackage : dsr_pkg

/* File: rtl/dsr_bit_sampler.sv */
// differential line sampler: one serial bit per clock
`timescale 1ns/1ps
module dsr_bit_sampler (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_pos,
  input wire logic i_neg,
  output logic o_bit
);
  import dsr_pkg::*;

  typedef struct packed {
    logic bit_val;
  } dsrs_st_t;

  dsrs_st_t st_ff;
  dsrs_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.bit_val = i_pos & ~i_neg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_bit = st_ff.bit_val;
endmodule : dsr_bit_sampler

/* File: rtl/dsr_word_buf.sv */
// small word buffer with valid/ready on both sides, registered read data
`timescale 1ns/1ps
module dsr_word_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  import dsr_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] rdata;
    logic rvalid;
  } dsrb_st_t;

  dsrb_st_t st_ff;
  dsrb_st_t nxt_st;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_C) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  always_comb begin
    logic push;
    logic pop;
    logic load;
    push = 1'b0;
    pop = 1'b0;
    load = 1'b0;
    nxt_st = st_ff;
    if (i_ce) begin
      // output register refills from memory when empty or being drained
      load = (st_ff.cnt != '0) && (!st_ff.rvalid || i_out_ready);
      push = i_in_valid && (st_ff.cnt != DEPTH_C);
      pop = load;
      if (st_ff.rvalid && i_out_ready) begin
        nxt_st.rvalid = 1'b0;
      end
      if (load) begin
        nxt_st.rdata = st_ff.mem[st_ff.rd];
        nxt_st.rvalid = 1'b1;
        nxt_st.rd = ptr_inc(st_ff.rd);
      end
      if (push) begin
        nxt_st.mem[st_ff.wr] = i_in_data;
        nxt_st.wr = ptr_inc(st_ff.wr);
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (i_flush) begin
        nxt_st.wr = '0;
        nxt_st.rd = '0;
        nxt_st.cnt = '0;
        nxt_st.rvalid = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_in_ready = (st_ff.cnt != DEPTH_C);
  assign o_out_valid = st_ff.rvalid;
  assign o_out_data = st_ff.rdata;
endmodule : dsr_word_buf

/* File: bench/dsr_deser_ctrl_assertions.sv */
// pin-level checks for the deserializer
`timescale 1ns/1ps
module dsr_deser_ctrl_assertions (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_power_down_n,
  input wire logic i_output_enable_n,
  input wire dsr_pkg::dsr_pins_t o_pins,
  input wire logic o_buf_ready,
  input wire logic o_word_dropped
);
  import dsr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  pd_float_a: assert property (!i_power_down_n |=>
    !o_pins.data_oe && !o_pins.rclk_oe && !o_pins.lock_oe) else $error("pins driven in pd");
  oen_float_a: assert property (!i_output_enable_n |=>
    !o_pins.data_oe && !o_pins.rclk_oe) else $error("pins driven with oe off");
  lock_kept_a: assert property (i_power_down_n && !o_pins.lock_n |=>
    o_pins.lock_oe) else $error("lock pin floated");
  unlock_float_a: assert property (o_pins.lock_n |->
    !o_pins.data_oe && !o_pins.rclk_oe) else $error("pins driven unlocked");
  rclk_idle_a: assert property (o_pins.lock_n |-> !o_pins.rclk)
    else $error("rclk runs unlocked");
  rclk_width_a: assert property ($fell(o_pins.rclk) && !o_pins.lock_n &&
    !$past(o_pins.lock_n, 7) |->
    $past(o_pins.rclk, 6) && !$past(o_pins.rclk, 7)) else $error("rclk high width");
  data_hold_a: assert property ($changed(o_pins.data) && o_pins.data_oe |=>
    ($stable(o_pins.data) || o_pins.lock_n || !o_pins.lock_oe)[*8]) else $error("data hold");
  drop_full_a: assert property (o_word_dropped |->
    !o_buf_ready ##1 !o_word_dropped) else $error("drop while not full");
  cover property ($fell(o_pins.lock_n));
  cover property ($rose(o_pins.lock_n));
  cover property (o_word_dropped);
endmodule : dsr_deser_ctrl_assertions
bind dsr_deser_ctrl dsr_deser_ctrl_assertions chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_power_down_n(i_power_down_n), .i_output_enable_n(i_output_enable_n), .o_pins(o_pins),
  .o_buf_ready(o_buf_ready), .o_word_dropped(o_word_dropped));

/* File: bench/dsr_ser_model.sv */
// serializer model: high clock bit, ten data bits msb first, low clock bit
`timescale 1ns/1ps
module dsr_ser_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [9:0] i_word,
  input wire logic i_bad,
  input wire logic i_sync,
  output logic o_pos,
  output logic o_neg,
  output logic o_take
);
  logic [3:0] cnt_ff;
  logic [9:0] w_ff;
  logic bad_ff;
  assign o_take = (cnt_ff == 4'hB);
  assign o_neg = ~o_pos;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= 4'h0;
      w_ff <= 10'h3E0;
      bad_ff <= 1'b0;
    end else begin
      cnt_ff <= o_take ? 4'h0 : cnt_ff + 4'h1;
      if (o_take) begin
        w_ff <= i_sync ? 10'h3E0 : i_word;
        bad_ff <= i_bad;
      end
    end
  end
  always_comb begin
    if (cnt_ff == 4'h0) o_pos = ~bad_ff;
    else if (cnt_ff == 4'hB) o_pos = bad_ff;
    else o_pos = w_ff[4'hA - cnt_ff];
  end
endmodule : dsr_ser_model

/* File: bench/dsr_deser_ctrl_tb.sv */
// self-checking bench for the deserializer
`timescale 1ns/1ps
module dsr_deser_ctrl_tb;
  import dsr_pkg::*;
  logic clk, rstn, pd_n, oe_n, sel, rdy, bad, pos, neg, take, ref_seen, buf_rdy;
  logic drop;
  logic ref_clk = 1'b0;
  logic drop_seen = 1'b0;
  logic [9:0] word;
  dsr_pins_t pins;
  int n_errors, comparisons, cyc;
  logic [9:0] tbl [4] = '{10'h2AA, 10'h155, 10'h3FF, 10'h001};
  dsr_ser_model ser (.i_clk(clk), .i_rstn(rstn), .i_word(word), .i_bad(bad),
    .i_sync(!pins.lock_oe || pins.lock_n), .o_pos(pos), .o_neg(neg), .o_take(take));
  dsr_deser_ctrl uut (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_local_ref_clk(ref_clk),
    .i_serial_in_pos(pos), .i_serial_in_neg(neg), .i_power_down_n(pd_n),
    .i_output_enable_n(oe_n), .i_strobe_edge_select(sel), .i_rx_ready(rdy), .o_pins(pins),
    .o_ref_seen(ref_seen), .o_buf_ready(buf_rdy), .o_word_dropped(drop));
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic wlock();
    int k;
    k = 0;
    while (pins.lock_n !== 1'b0 && k < 300) begin
      step(1);
      k++;
    end
  endtask : wlock
  task automatic t_lock();
    wlock();
    chk(pins.lock_n === 1'b0 && pins.lock_oe === 1'b1, "no lock");
    chk(ref_seen === 1'b1, "ref clock unseen");
    $display("lock test done");
  endtask : t_lock
  task automatic t_data();
    int k;
    foreach (tbl[i]) begin
      @(posedge clk);
      word <= tbl[i];
      k = 0;
      while (pins.data !== tbl[i] && k < 80) begin
        step(1);
        k++;
      end
      chk(pins.data === tbl[i] && pins.data_oe === 1'b1, "data word");
      chk(pins.rclk === !sel && pins.rclk_oe === 1'b1, "rclk phase");
      step(6);
      chk(pins.rclk === sel, "rclk edge");
    end
    $display("data test done");
  endtask : t_data
  task automatic t_oen();
    @(posedge clk);
    oe_n <= 1'b0;
    step(3);
    chk(!pins.data_oe && !pins.rclk_oe && pins.lock_oe === 1'b1, "oe off");
    @(posedge clk);
    oe_n <= 1'b1;
    step(3);
    $display("oe test done");
  endtask : t_oen
  task automatic t_stall();
    logic [9:0] d0;
    d0 = pins.data;
    @(posedge clk);
    rdy <= 1'b0;
    word <= 10'h0F0;
    step(72);
    chk(drop_seen === 1'b1 && buf_rdy === 1'b0, "no drop when full");
    chk(pins.data === d0, "data moved in stall");
    @(posedge clk);
    rdy <= 1'b1;
    step(60);
    chk(pins.data === 10'h0F0, "word after stall");
    $display("stall test done");
  endtask : t_stall
  task automatic bad_frames(input int n);
    while (take !== 1'b1) step(1);
    @(posedge clk);
    bad <= 1'b1;
    repeat (n) begin
      step(1);
      while (take !== 1'b1) step(1);
      @(posedge clk);
    end
    bad <= 1'b0;
  endtask : bad_frames
  task automatic t_loss();
    bad_frames(3);
    step(40);
    chk(pins.lock_n === 1'b0, "lock lost early");
    bad_frames(4);
    step(18);
    chk(pins.lock_n === 1'b1 && !pins.data_oe && !pins.rclk_oe, "lock kept");
    chk(pins.rclk === 1'b0, "rclk runs");
    wlock();
    chk(pins.lock_n === 1'b0, "no relock");
    $display("loss test done");
  endtask : t_loss
  task automatic t_pd();
    @(posedge clk);
    pd_n <= 1'b0;
    step(3);
    chk(!pins.data_oe && !pins.rclk_oe && !pins.lock_oe, "pd drives");
    @(posedge clk);
    sel <= 1'b0;
    pd_n <= 1'b1;
    t_lock();
    t_data();
    $display("pd test done");
  endtask : t_pd
  task automatic end_of_test();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ref_clk <= ~ref_clk;
    if (drop === 1'b1) drop_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    {rstn, bad} = 2'h0;
    {pd_n, oe_n, sel, rdy} = 4'hF;
    word = 10'h000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_lock();
    t_data();
    t_oen();
    t_stall();
    t_loss();
    t_pd();
    end_of_test();
  end
endmodule : dsr_deser_ctrl_tb
